// ===== ptp_pkg.sv
// shared constants for the paper tape punch and reader controller
package ptp_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // io transfer instruction layout
  localparam int unsigned INSTR_W      = 12;
  localparam int unsigned OP_MSB       = 11;
  localparam int unsigned OP_LSB       = 9;
  localparam int unsigned DEV_MSB      = 8;
  localparam int unsigned DEV_LSB      = 3;
  localparam int unsigned IOP1_BIT     = 0;
  localparam int unsigned IOP2_BIT     = 1;
  localparam int unsigned IOP3_BIT     = 2;
  localparam logic [2:0]  XFR_OPCODE   = 3'h6;
  localparam logic [5:0]  DEV_READER   = 6'h01;
  localparam logic [5:0]  DEV_PUNCH    = 6'h02;

  ////////////////////////////////////////////////////////////////////////////////
  // characters
  localparam int unsigned CHAR_W       = 8;
  localparam logic [7:0]  CHAR_RESET   = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // mechanism timing
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned PUNCH_RATE_CPS  = 50;
  localparam int unsigned READER_RATE_CPS = 300;
  localparam int unsigned PUNCH_CYCLES    = (CLK_HZ + PUNCH_RATE_CPS - 1) / PUNCH_RATE_CPS;
  localparam int unsigned READER_CYCLES   = (CLK_HZ + READER_RATE_CPS - 1) / READER_RATE_CPS;
  localparam int unsigned TMR_W           = 20;

  ////////////////////////////////////////////////////////////////////////////////
  // register map
  localparam int unsigned REG_AW          = 8;
  localparam int unsigned DATA_W          = 32;
  localparam logic [7:0]  REG_STATUS      = 8'h00;
  localparam logic [7:0]  REG_CLEAR       = 8'h04;
  localparam logic [7:0]  REG_ENABLE      = 8'h08;
  localparam logic [7:0]  REG_FLAGS       = 8'h0C;
  localparam logic [7:0]  REG_PUNCH_CHAR  = 8'h10;
  localparam logic [7:0]  REG_READER_CHAR = 8'h14;
  localparam int unsigned EVT_W           = 2;
  localparam int unsigned EVT_PUNCH       = 0;
  localparam int unsigned EVT_READER      = 1;
  localparam int unsigned FLG_W           = 4;
  localparam logic [1:0]  EVT_RESET       = 2'h0;

endpackage

// ===== ptp_cycle_timer.sv
// down counter that marks the least time of one mechanism cycle
`timescale 1ns/1ps
module ptp_cycle_timer #(
  parameter int unsigned W    = 20,
  parameter int unsigned LOAD = 800000
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic start,
  output logic      expired_ff
);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  assign nxt_cnt = start ? W'(LOAD) : ((cnt_ff != '0) ? cnt_ff - W'(1) : cnt_ff);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_ff     <= '0;
      expired_ff <= 1'b1;
    end else begin
      cnt_ff     <= nxt_cnt;
      expired_ff <= (nxt_cnt == '0);
    end
  end

endmodule

// ===== ptp_regs.sv
// register port slave with sticky event status, clear, enable and interrupt
`timescale 1ns/1ps
module ptp_regs
  import ptp_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic [REG_AW-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [EVT_W-1:0]  evt_set,
  input  wire logic [FLG_W-1:0]  flags,
  input  wire logic [CHAR_W-1:0] punch_char,
  input  wire logic [CHAR_W-1:0] reader_char,
  output logic [DATA_W-1:0]      reg_rdata_ff,
  output logic                   irq_ff
);

  logic [EVT_W-1:0]  status_ff;
  logic [EVT_W-1:0]  enable_ff;
  logic [EVT_W-1:0]  nxt_status;
  logic [EVT_W-1:0]  nxt_enable;
  logic [EVT_W-1:0]  clear_mask;
  logic              wr_clear;
  logic              wr_enable;
  logic [DATA_W-1:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////////////
  // decode
  assign wr_clear   = reg_wr && (reg_addr == REG_CLEAR);
  assign wr_enable  = reg_wr && (reg_addr == REG_ENABLE);
  assign clear_mask = wr_clear ? reg_wdata[EVT_W-1:0] : EVT_RESET;
  // a new event beats a clear in the same cycle
  assign nxt_status = evt_set | (status_ff & ~clear_mask);
  assign nxt_enable = wr_enable ? reg_wdata[EVT_W-1:0] : enable_ff;
  // clear register is write-only, unmapped reads return zero
  assign rd_mux =
    (reg_addr == REG_STATUS)      ? {{(DATA_W-EVT_W){1'b0}}, status_ff} :
    (reg_addr == REG_ENABLE)      ? {{(DATA_W-EVT_W){1'b0}}, enable_ff} :
    (reg_addr == REG_FLAGS)       ? {{(DATA_W-FLG_W){1'b0}}, flags} :
    (reg_addr == REG_PUNCH_CHAR)  ? {{(DATA_W-CHAR_W){1'b0}}, punch_char} :
    (reg_addr == REG_READER_CHAR) ? {{(DATA_W-CHAR_W){1'b0}}, reader_char} :
    '0;

  ////////////////////////////////////////////////////////////////////////////////
  // state
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      status_ff    <= EVT_RESET;
      enable_ff    <= EVT_RESET;
      irq_ff       <= 1'b0;
      reg_rdata_ff <= '0;
    end else begin
      status_ff    <= nxt_status;
      enable_ff    <= nxt_enable;
      irq_ff       <= |(nxt_status & nxt_enable);
      reg_rdata_ff <= reg_rd ? rd_mux : '0;
    end
  end

endmodule

// ===== ptp_ctrl.sv
// paper tape punch and reader controller on the programmed io bus
//
// Summary of operation
// - The punch keeps an 8-bit character register loaded from accumulator bits 4-11.
// - One punch cycle lasts at least the time of one character at 50 per second.
// - The punch done flag is set when the punch finishes a character.
// - Punch skip on the first pulse raises the skip request when the punch flag is set.
// - Punch clear on the second pulse clears the punch flag and character register.
// - Load and punch on the third pulse loads the register and starts punching.
// - The combined sequence clears on pulse two, loads and punches on pulse three.
// - The reader catches each row of eight holes into an 8-bit register, at most 300 per second.
// - Clearing the reader flag starts tape motion for the next character.
// - The reader flag drives the interrupt request and skip and only io pulses clear it.
// - Reader skip on the first pulse raises the skip request when the reader flag is set.
// - Read reader char hands the register to be ORed into the accumulator and clears the flag.
// - Fetch on the third pulse clears flag and register, reads one character, sets the flag.
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ps
module ptp_ctrl
  import ptp_pkg::*;
#(
  parameter int unsigned PUNCH_CYC  = PUNCH_CYCLES,
  parameter int unsigned READER_CYC = READER_CYCLES
) (
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire logic [INSTR_W-1:0] io_instr,
  input  wire logic               io_pulse1,
  input  wire logic               io_pulse2,
  input  wire logic               io_pulse3,
  input  wire logic [INSTR_W-1:0] io_acc,
  output logic                    io_skip_ff,
  output logic                    io_int_req_ff,
  output logic                    io_rd_en_ff,
  output logic [CHAR_W-1:0]       io_rd_data_ff,
  output logic [CHAR_W-1:0]       punch_char_ff,
  output logic                    punch_go_ff,
  output logic                    rdr_adv_ff,
  input  wire logic               rdr_strobe,
  input  wire logic [CHAR_W-1:0]  rdr_holes,
  input  wire logic [REG_AW-1:0]  reg_addr,
  input  wire logic [DATA_W-1:0]  reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [DATA_W-1:0]       reg_rdata_ff,
  output logic                    irq_ff
);

  typedef enum logic [0:0] {PUN_IDLE, PUN_BUSY} ptp_pun_state_t;
  typedef enum logic [1:0] {RDR_IDLE, RDR_MOVE, RDR_HOLD} ptp_rdr_state_t;

  logic           op_is_xfr;
  logic [5:0]     dev_field;
  logic           sel_pun;
  logic           sel_rdr;
  logic           ev1;
  logic           ev2;
  logic           ev3;
  logic           pun_skip;
  logic           pun_clr;
  logic           pun_load;
  logic           rdr_skip;
  logic           rdr_read;
  logic           rdr_fetch;
  logic           rdr_clear;
  logic           rdr_start;
  logic           rdr_catch;
  logic           punch_done;
  logic           rdr_done;
  logic           pun_tmr_exp;
  logic           rdr_tmr_exp;
  ptp_pun_state_t pun_state_ff;
  ptp_pun_state_t nxt_pun_state;
  ptp_rdr_state_t rdr_state_ff;
  ptp_rdr_state_t nxt_rdr_state;
  logic           punch_flag_ff;
  logic           nxt_punch_flag;
  logic           reader_flag_ff;
  logic           nxt_reader_flag;
  logic [CHAR_W-1:0] nxt_punch_char;
  logic [CHAR_W-1:0] reader_char_ff;
  logic [CHAR_W-1:0] nxt_reader_char;
  logic [FLG_W-1:0]  flags;

  ////////////////////////////////////////////////////////////////////////////////
  // instruction decode
  assign op_is_xfr = (io_instr[OP_MSB:OP_LSB] == XFR_OPCODE);
  assign dev_field = io_instr[DEV_MSB:DEV_LSB];
  assign sel_pun   = op_is_xfr && (dev_field == DEV_PUNCH);
  assign sel_rdr   = op_is_xfr && (dev_field == DEV_READER);
  assign ev1       = io_pulse1 && io_instr[IOP1_BIT];
  assign ev2       = io_pulse2 && io_instr[IOP2_BIT];
  assign ev3       = io_pulse3 && io_instr[IOP3_BIT];
  assign pun_skip  = sel_pun && ev1;
  assign pun_clr   = sel_pun && ev2;
  assign pun_load  = sel_pun && ev3;
  assign rdr_skip  = sel_rdr && ev1;
  assign rdr_read  = sel_rdr && ev2;
  assign rdr_fetch = sel_rdr && ev3;

  ////////////////////////////////////////////////////////////////////////////////
  // punch side
  ptp_cycle_timer #(
    .W    (TMR_W),
    .LOAD (PUNCH_CYC)
  ) u_pun_tmr (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .start      (pun_load),
    .expired_ff (pun_tmr_exp)
  );

  // a load while busy restarts the cycle with the new character
  assign punch_done = (pun_state_ff == PUN_BUSY) && pun_tmr_exp && !pun_load;

  always_comb begin
    nxt_pun_state = pun_state_ff;
    case (pun_state_ff)
      PUN_IDLE: begin
        if (pun_load) begin
          nxt_pun_state = PUN_BUSY;
        end
      end
      PUN_BUSY: begin
        if (punch_done) begin
          nxt_pun_state = PUN_IDLE;
        end
      end
      default: begin
        nxt_pun_state = PUN_IDLE;
      end
    endcase
  end

  // set beats clear so a completion is never lost
  assign nxt_punch_flag = punch_done ? 1'b1 : (pun_clr ? 1'b0 : punch_flag_ff);
  assign nxt_punch_char = pun_load ? io_acc[CHAR_W-1:0] :
                          (pun_clr ? CHAR_RESET : punch_char_ff);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pun_state_ff  <= PUN_IDLE;
      punch_flag_ff <= 1'b0;
      punch_char_ff <= CHAR_RESET;
      punch_go_ff   <= 1'b0;
    end else begin
      pun_state_ff  <= nxt_pun_state;
      punch_flag_ff <= nxt_punch_flag;
      punch_char_ff <= nxt_punch_char;
      punch_go_ff   <= pun_load;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // reader side
  assign rdr_clear = rdr_read || rdr_fetch;
  // a clear during motion does not restart the tape, the row in flight is kept
  assign rdr_start = rdr_clear && (rdr_state_ff == RDR_IDLE);
  assign rdr_catch = (rdr_state_ff == RDR_MOVE) && rdr_strobe;
  assign rdr_done  = (rdr_state_ff == RDR_HOLD) && rdr_tmr_exp;

  ptp_cycle_timer #(
    .W    (TMR_W),
    .LOAD (READER_CYC)
  ) u_rdr_tmr (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .start      (rdr_start),
    .expired_ff (rdr_tmr_exp)
  );

  always_comb begin
    nxt_rdr_state = rdr_state_ff;
    case (rdr_state_ff)
      RDR_IDLE: begin
        if (rdr_start) begin
          nxt_rdr_state = RDR_MOVE;
        end
      end
      RDR_MOVE: begin
        if (rdr_catch) begin
          nxt_rdr_state = RDR_HOLD;
        end
      end
      RDR_HOLD: begin
        if (rdr_done) begin
          nxt_rdr_state = RDR_IDLE;
        end
      end
      default: begin
        nxt_rdr_state = RDR_IDLE;
      end
    endcase
  end

  assign nxt_reader_flag = rdr_done ? 1'b1 : (rdr_clear ? 1'b0 : reader_flag_ff);
  // a caught row is newer than a fetch clear in the same cycle
  assign nxt_reader_char = rdr_catch ? rdr_holes :
                           (rdr_fetch ? CHAR_RESET : reader_char_ff);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdr_state_ff   <= RDR_IDLE;
      reader_flag_ff <= 1'b0;
      reader_char_ff <= CHAR_RESET;
      rdr_adv_ff     <= 1'b0;
    end else begin
      rdr_state_ff   <= nxt_rdr_state;
      reader_flag_ff <= nxt_reader_flag;
      reader_char_ff <= nxt_reader_char;
      rdr_adv_ff     <= (nxt_rdr_state == RDR_MOVE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // processor bus answers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      io_skip_ff    <= 1'b0;
      io_int_req_ff <= 1'b0;
      io_rd_en_ff   <= 1'b0;
      io_rd_data_ff <= CHAR_RESET;
    end else begin
      io_skip_ff    <= (pun_skip && punch_flag_ff) || (rdr_skip && reader_flag_ff);
      io_int_req_ff <= nxt_punch_flag || nxt_reader_flag;
      io_rd_en_ff   <= rdr_read;
      io_rd_data_ff <= rdr_read ? reader_char_ff : CHAR_RESET;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // software registers and interrupt
  assign flags = {(rdr_state_ff != RDR_IDLE), (pun_state_ff != PUN_IDLE),
                  reader_flag_ff, punch_flag_ff};

  ptp_regs u_regs (
    .sys_clk      (sys_clk),
    .rst          (rst),
    .reg_addr     (reg_addr),
    .reg_wdata    (reg_wdata),
    .reg_wr       (reg_wr),
    .reg_rd       (reg_rd),
    .evt_set      ({rdr_done, punch_done}),
    .flags        (flags),
    .punch_char   (punch_char_ff),
    .reader_char  (reader_char_ff),
    .reg_rdata_ff (reg_rdata_ff),
    .irq_ff       (irq_ff)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  logic [31:0] pun_elapsed_ff;

  // cycles since the last load, saturating so it never wraps to a false match
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pun_elapsed_ff <= '0;
    end else if (pun_load) begin
      pun_elapsed_ff <= 32'h00000001;
    end else if (pun_elapsed_ff != 32'hFFFFFFFF) begin
      pun_elapsed_ff <= pun_elapsed_ff + 32'h00000001;
    end
  end

  punch_skip_a: assert property (
    @(posedge sys_clk) disable iff (rst) (pun_skip && punch_flag_ff) |=> io_skip_ff)
    else $error("punch skip not raised");

  reader_skip_a: assert property (
    @(posedge sys_clk) disable iff (rst) (rdr_skip && reader_flag_ff) |=> io_skip_ff)
    else $error("reader skip not raised");

  foreign_skip_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    !((pun_skip && punch_flag_ff) || (rdr_skip && reader_flag_ff)) |=> !io_skip_ff)
    else $error("skip raised without cause");

  punch_clear_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (pun_clr && !punch_done && !pun_load) |=> (!punch_flag_ff && punch_char_ff == CHAR_RESET))
    else $error("punch clear left flag or character");

  punch_load_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    pun_load |=> (punch_go_ff && punch_char_ff == $past(io_acc[CHAR_W-1:0])))
    else $error("punch character not loaded");

  punch_go_pulse_a: assert property (
    @(posedge sys_clk) disable iff (rst) punch_go_ff |-> $past(pun_load))
    else $error("punch start without load");

  punch_time_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    ($rose(punch_flag_ff) && pun_elapsed_ff != 32'h00000000) |-> (pun_elapsed_ff == PUNCH_CYC + 2))
    else $error("punch cycle length wrong");

  punch_done_a: assert property (
    @(posedge sys_clk) disable iff (rst) punch_done |=> (punch_flag_ff && pun_state_ff == PUN_IDLE))
    else $error("punch completion did not set flag");

  int_req_a: assert property (
    @(posedge sys_clk) disable iff (rst) io_int_req_ff == (punch_flag_ff || reader_flag_ff))
    else $error("interrupt request does not follow flags");

  reader_start_a: assert property (
    @(posedge sys_clk) disable iff (rst) rdr_start |=> (rdr_adv_ff && !reader_flag_ff))
    else $error("tape motion not started by flag clear");

  reader_read_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (rdr_read && !rdr_done) |=> (io_rd_en_ff && !reader_flag_ff &&
                                 io_rd_data_ff == $past(reader_char_ff)))
    else $error("reader character not handed over");

  reader_catch_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    rdr_catch |=> (!rdr_adv_ff && reader_char_ff == $past(rdr_holes)))
    else $error("tape row not caught");

  reader_fetch_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (rdr_fetch && !rdr_done && !rdr_catch) |=> (!reader_flag_ff && reader_char_ff == CHAR_RESET))
    else $error("fetch did not clear reader");

  reader_done_a: assert property (
    @(posedge sys_clk) disable iff (rst) rdr_done |=> (reader_flag_ff && rdr_state_ff == RDR_IDLE))
    else $error("reader completion did not set flag");

  reader_flag_hold_a: assert property (
    @(posedge sys_clk) disable iff (rst) (reader_flag_ff && !rdr_clear) |=> reader_flag_ff)
    else $error("reader flag dropped without io pulse");

endmodule

// ===== ptp_tape_model.sv
// behavioural tape reader and punch mechanisms on the far side of the controller
`timescale 1ns/1ps
module ptp_tape_model
  import ptp_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              rdr_adv_ff,
  input  wire logic              punch_go_ff,
  input  wire logic [CHAR_W-1:0] punch_char_ff,
  input  wire logic [CHAR_W-1:0] tape_char,
  input  wire logic              slow,
  output logic                   rdr_strobe,
  output logic [CHAR_W-1:0]      rdr_holes,
  output logic [CHAR_W-1:0]      punched_ff
);
  int   cnt_ff;
  logic sent_ff;

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    if (rst) begin
      rdr_strobe <= 1'b0;
      rdr_holes  <= 8'h00;
      punched_ff <= 8'h00;
      cnt_ff     <= 0;
      sent_ff    <= 1'b0;
    end else begin
      rdr_strobe <= 1'b0;
      // holes keep changing outside a strobe so a stale row never looks valid
      rdr_holes <= ~rdr_holes;
      if (!rdr_adv_ff) begin
        cnt_ff <= 0;
        sent_ff <= 1'b0;
      end else if (!sent_ff) begin
        if (cnt_ff == (slow ? 15 : 2)) begin
          rdr_strobe <= 1'b1;
          rdr_holes <= tape_char;
          sent_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff + 1;
        end
      end
      if (punch_go_ff) begin
        punched_ff <= punch_char_ff;
      end
    end
  end
endmodule

// ===== ptp_ctrl_tb.sv
// self-checking bench for the punch and reader controller
`timescale 1ns/1ps
module ptp_ctrl_tb
  import ptp_pkg::*;
;
  localparam int unsigned PUN_SIM_CYC = 20;
  logic sys_clk = 1'b0, rst = 1'b1, io_pulse1 = 1'b0, io_pulse2 = 1'b0, io_pulse3 = 1'b0;
  logic [INSTR_W-1:0] io_instr = 12'h000, io_acc = 12'h000;
  logic io_skip_ff, io_int_req_ff, io_rd_en_ff, punch_go_ff, rdr_adv_ff, rdr_strobe, irq_ff;
  logic [CHAR_W-1:0] io_rd_data_ff, punch_char_ff, rdr_holes, punched_ff;
  logic [CHAR_W-1:0] tape_char = 8'hC3;
  logic slow = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [REG_AW-1:0] reg_addr = 8'h00;
  logic [DATA_W-1:0] reg_wdata = 32'h0, reg_rdata_ff, rd;
  int fails = 0, tests_run = 0, n;

  always #12.5 sys_clk = ~sys_clk;

  ptp_ctrl #(.PUNCH_CYC(PUN_SIM_CYC), .READER_CYC(10)) uut (.sys_clk(sys_clk), .rst(rst),
    .io_instr(io_instr), .io_pulse1(io_pulse1), .io_pulse2(io_pulse2), .io_pulse3(io_pulse3),
    .io_acc(io_acc), .io_skip_ff(io_skip_ff), .io_int_req_ff(io_int_req_ff),
    .io_rd_en_ff(io_rd_en_ff), .io_rd_data_ff(io_rd_data_ff), .punch_char_ff(punch_char_ff),
    .punch_go_ff(punch_go_ff), .rdr_adv_ff(rdr_adv_ff), .rdr_strobe(rdr_strobe),
    .rdr_holes(rdr_holes), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .irq_ff(irq_ff));

  ptp_tape_model mech (.sys_clk(sys_clk), .rst(rst), .rdr_adv_ff(rdr_adv_ff),
    .punch_go_ff(punch_go_ff), .punch_char_ff(punch_char_ff), .tape_char(tape_char),
    .slow(slow), .rdr_strobe(rdr_strobe), .rdr_holes(rdr_holes), .punched_ff(punched_ff));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one event pulse p of an io transfer; returns just after the answering edge
  task automatic xfer(input logic [5:0] dev, input logic [2:0] bits, input int p);
    @(posedge sys_clk);
    io_instr <= {XFR_OPCODE, dev, bits};
    io_pulse1 <= (p == 1);
    io_pulse2 <= (p == 2);
    io_pulse3 <= (p == 3);
    @(posedge sys_clk);
    io_pulse1 <= 1'b0;
    io_pulse2 <= 1'b0;
    io_pulse3 <= 1'b0;
    #1;
  endtask

  task automatic wait_int(input logic lvl);
    n = 0;
    while (io_int_req_ff !== lvl && n < 200) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk(io_int_req_ff, lvl);
  endtask

  task automatic reg_wr_t(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic reg_rd_t(input logic [7:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    rd = reg_rdata_ff;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    chk({io_skip_ff, punch_go_ff, io_int_req_ff, rdr_adv_ff, irq_ff}, 32'h0);
    chk(punch_char_ff, 32'h0);
    reg_rd_t(REG_FLAGS);
    chk(rd, 32'h0);
    $display("reset test done");
  endtask

  task automatic test_punch();
    xfer(DEV_PUNCH, 3'h1, 1);
    chk(io_skip_ff, 1'b0);
    io_acc <= 12'hFA5;
    xfer(DEV_PUNCH, 3'h6, 2);
    chk(punch_char_ff, 32'h0);
    xfer(DEV_PUNCH, 3'h6, 3);
    chk({punch_go_ff, punch_char_ff}, 32'h1A5);
    wait_int(1'b1);
    chk(n, PUN_SIM_CYC + 1);
    chk(punched_ff, 32'hA5);
    xfer(DEV_PUNCH, 3'h1, 1);
    chk(io_skip_ff, 1'b1);
    xfer(6'h03, 3'h2, 2);
    chk(io_int_req_ff, 1'b1);
    io_acc <= 12'h03C;
    xfer(DEV_PUNCH, 3'h4, 3);
    chk({io_int_req_ff, punch_go_ff, punch_char_ff}, 32'h33C);
    repeat (PUN_SIM_CYC + 4) @(posedge sys_clk);
    xfer(DEV_PUNCH, 3'h2, 2);
    chk({io_int_req_ff, punch_char_ff}, 32'h0);
    $display("punch test done");
  endtask

  task automatic test_reader();
    xfer(DEV_READER, 3'h1, 1);
    chk(io_skip_ff, 1'b0);
    xfer(DEV_READER, 3'h4, 3);
    chk({rdr_adv_ff, io_int_req_ff}, 32'h2);
    wait_int(1'b1);
    chk(io_int_req_ff, 1'b1);
    xfer(DEV_READER, 3'h1, 1);
    chk(io_skip_ff, 1'b1);
    tape_char <= 8'h5A;
    slow <= 1'b0;
    xfer(DEV_READER, 3'h2, 2);
    chk({io_rd_en_ff, io_rd_data_ff}, 32'h1C3);
    chk({io_int_req_ff, rdr_adv_ff}, 32'h1);
    wait_int(1'b1);
    xfer(DEV_READER, 3'h2, 2);
    chk({io_rd_en_ff, io_rd_data_ff}, 32'h15A);
    wait_int(1'b1);
    xfer(DEV_READER, 3'h4, 3);
    chk(io_int_req_ff, 1'b0);
    wait_int(1'b1);
    chk(io_int_req_ff, 1'b1);
    $display("reader test done");
  endtask

  task automatic test_regs();
    reg_rd_t(REG_STATUS);
    chk(rd & 32'h3, 32'h3);
    chk(irq_ff, 1'b0);
    reg_wr_t(REG_ENABLE, 32'h1);
    chk(irq_ff, 1'b1);
    reg_wr_t(REG_CLEAR, 32'h1);
    chk(irq_ff, 1'b0);
    reg_wr_t(REG_ENABLE, 32'h2);
    chk(irq_ff, 1'b1);
    reg_wr_t(REG_STATUS, 32'h0);
    reg_rd_t(REG_STATUS);
    chk(rd & 32'h3, 32'h2);
    reg_rd_t(REG_ENABLE);
    chk(rd & 32'h3, 32'h2);
    reg_rd_t(8'h20);
    chk(rd, 32'h0);
    reg_rd_t(REG_READER_CHAR);
    chk(rd, 32'h5A);
    reg_rd_t(REG_PUNCH_CHAR);
    chk(rd, 32'h0);
    reg_rd_t(REG_FLAGS);
    chk(rd, 32'h2);
    reg_wr_t(REG_CLEAR, 32'h2);
    chk(irq_ff, 1'b0);
    $display("register test done");
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    test_reset();
    test_punch();
    test_reader();
    test_regs();
    summarize();
  end

  // the tests need well under two thousand cycles
  initial begin
    #(20000 * 25);
    fails++;
    summarize();
  end
endmodule
